//--- rtl/gpioin_top.sv
// Purpose: per-core live view of 32 pin levels plus AXI4-Lite register access
// Assumes: pins_in asynchronous to aclk; synchronous active-low reset
// Notes:   range select picks first and last pin for the range result register
//
// Implementation choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module gpioin_top #(
  parameter int NUM_CORES = 8
) (
  input  wire  logic                          aclk,
  input  wire  logic                          aresetn,
  input  wire  logic [31:0]                   pins_in,
  output logic [NUM_CORES-1:0][31:0]          core_pin_levels,
  input  wire  logic [gpioin_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire  logic                          s_axi_awvalid,
  output logic                                s_axi_awready,
  input  wire  logic [31:0]                   s_axi_wdata,
  input  wire  logic [3:0]                    s_axi_wstrb,
  input  wire  logic                          s_axi_wvalid,
  output logic                                s_axi_wready,
  output logic [1:0]                          s_axi_bresp,
  output logic                                s_axi_bvalid,
  input  wire  logic                          s_axi_bready,
  input  wire  logic [gpioin_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire  logic                          s_axi_arvalid,
  output logic                                s_axi_arready,
  output logic [31:0]                         s_axi_rdata,
  output logic [1:0]                          s_axi_rresp,
  output logic                                s_axi_rvalid,
  input  wire  logic                          s_axi_rready
);
  import gpioin_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    logic [31:0]                 sync_meta;
    logic [31:0]                 sync_level;
    logic [NUM_CORES-1:0][31:0]  views;
    gpioin_range_sel_t           sel;
    gpioin_addr_req_t            aw;
    gpioin_wdata_req_t           w;
    logic                        awready;
    logic                        wready;
    logic                        bvalid;
    logic [1:0]                  bresp;
    logic                        arready;
    logic                        rvalid;
    logic [31:0]                 rdata;
    logic [1:0]                  rresp;
  } gpioin_state_t;

  localparam gpioin_state_t STATE_RESET = '{
    sync_meta:  LEVELS_RESET,
    sync_level: LEVELS_RESET,
    views:      '0,
    sel:        '0,
    aw:         '0,
    w:          '0,
    awready:    1'b1,
    wready:     1'b1,
    bvalid:     1'b0,
    bresp:      RESP_OKAY,
    arready:    1'b1,
    rvalid:     1'b0,
    rdata:      '0,
    rresp:      RESP_OKAY
  };

  gpioin_state_t s_reg;
  gpioin_state_t s_next;

  // ==========================================================
  // next state
  always_comb
  begin
    s_next = s_reg;
    // two-flop synchroniser, first stage read only by second
    s_next.sync_meta  = pins_in;
    s_next.sync_level = s_reg.sync_meta;
    // each core gets its own copy of all pins, no arbitration
    for (int c = 0; c < NUM_CORES; c++)
      s_next.views[c] = s_reg.sync_level;

    // write address and data taken independently
    if (s_axi_awvalid && s_reg.awready)
    begin
      s_next.awready = 1'b0;
      s_next.aw      = '{valid: 1'b1, addr: s_axi_awaddr};
    end
    if (s_axi_wvalid && s_reg.wready)
    begin
      s_next.wready = 1'b0;
      s_next.w      = '{valid: 1'b1, data: s_axi_wdata, strb: s_axi_wstrb};
    end

    // both halves present: commit and answer
    if (s_reg.aw.valid && s_reg.w.valid && !s_reg.bvalid)
    begin
      s_next.aw.valid = 1'b0;
      s_next.w.valid  = 1'b0;
      s_next.bvalid   = 1'b1;
      if (s_reg.aw.addr == OFS_RANGE_SEL)
      begin
        s_next.bresp = RESP_OKAY;
        if (s_reg.w.strb[0])
          s_next.sel.first = s_reg.w.data[SEL_FIRST_LSB +: PIN_IDX_W];
        if (s_reg.w.strb[1])
          s_next.sel.last = s_reg.w.data[SEL_LAST_LSB +: PIN_IDX_W];
      end
      else
        s_next.bresp = RESP_SLVERR;
    end
    if (s_reg.bvalid && s_axi_bready)
    begin
      s_next.bvalid  = 1'b0;
      s_next.awready = 1'b1;
      s_next.wready  = 1'b1;
    end

    // reads sample the synchronised pins in the accepting cycle
    if (s_axi_arvalid && s_reg.arready)
    begin
      s_next.arready = 1'b0;
      s_next.rvalid  = 1'b1;
      s_next.rresp   = RESP_OKAY;
      unique case (s_axi_araddr)
        OFS_PORT_A:    s_next.rdata = s_reg.sync_level;
        OFS_PORT_B:    s_next.rdata = PORT_B_VALUE;
        OFS_RANGE_SEL: s_next.rdata = {19'h0, s_reg.sel.last, 3'h0, s_reg.sel.first};
        OFS_RANGE_RES: s_next.rdata = gpioin_extract(s_reg.sync_level,
                                                     s_reg.sel.first,
                                                     s_reg.sel.last);
        default:
        begin
          s_next.rdata = '0;
          s_next.rresp = RESP_SLVERR;
        end
      endcase
    end
    if (s_reg.rvalid && s_axi_rready)
    begin
      s_next.rvalid  = 1'b0;
      s_next.arready = 1'b1;
    end
  end

  // state register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_reg <= STATE_RESET;
    else
      s_reg <= s_next;
  end

  // outputs straight from the state register
  assign core_pin_levels = s_reg.views;
  assign s_axi_awready   = s_reg.awready;
  assign s_axi_wready    = s_reg.wready;
  assign s_axi_bvalid    = s_reg.bvalid;
  assign s_axi_bresp     = s_reg.bresp;
  assign s_axi_arready   = s_reg.arready;
  assign s_axi_rvalid    = s_reg.rvalid;
  assign s_axi_rdata     = s_reg.rdata;
  assign s_axi_rresp     = s_reg.rresp;

  // ==========================================================
  // checks
  logic        ar_take;
  logic [31:0] span_mask;
  int          span;

  // helper terms for the checks
  assign ar_take = s_axi_arvalid && s_reg.arready;
  always_comb
  begin
    span = (s_reg.sel.first >= s_reg.sel.last) ?
           int'(s_reg.sel.first) - int'(s_reg.sel.last) :
           int'(s_reg.sel.last) - int'(s_reg.sel.first);
    span_mask = '0;
    for (int k = 0; k < 32; k++)
      span_mask[k] = (k <= span);
  end

  sequence q_read_of(logic [3:0] a);
    ar_take && (s_axi_araddr == a);
  endsequence

  property p_sync_delay;
    @(posedge aclk) disable iff (!aresetn)
    $past(aresetn, 2) |-> s_reg.sync_level == $past(pins_in, 2);
  endproperty
  a_sync_delay: assert property (p_sync_delay)
    else $error("pin level not two cycles behind pin");

  property p_view_bits;
    @(posedge aclk) disable iff (!aresetn)
    $past(aresetn, 3) |-> core_pin_levels[0] == $past(pins_in, 3);
  endproperty
  a_view_bits: assert property (p_view_bits)
    else $error("core view does not match pins");

  property p_view_high;
    @(posedge aclk) disable iff (!aresetn)
    ($past(aresetn, 3) && $past(pins_in[0], 3)) |-> core_pin_levels[0][0];
  endproperty
  a_view_high: assert property (p_view_high)
    else $error("high pin read as zero");

  property p_views_equal;
    @(posedge aclk) disable iff (!aresetn)
    core_pin_levels[NUM_CORES-1] == core_pin_levels[0];
  endproperty
  a_views_equal: assert property (p_views_equal)
    else $error("core views differ");

  property p_port_a_read;
    @(posedge aclk) disable iff (!aresetn)
    q_read_of(OFS_PORT_A) |=> s_axi_rvalid && s_axi_rdata == $past(s_reg.sync_level)
                              && s_axi_rresp == RESP_OKAY;
  endproperty
  a_port_a_read: assert property (p_port_a_read)
    else $error("port read not sampled at access");

  property p_port_b_zero;
    @(posedge aclk) disable iff (!aresetn)
    q_read_of(OFS_PORT_B) |=> s_axi_rvalid && s_axi_rdata == PORT_B_VALUE;
  endproperty
  a_port_b_zero: assert property (p_port_b_zero)
    else $error("reserved port returned data");

  property p_single_pin;
    @(posedge aclk) disable iff (!aresetn)
    (q_read_of(OFS_RANGE_RES) and (s_reg.sel.first == s_reg.sel.last)) |=>
      s_axi_rdata[31:1] == 31'h0 &&
      s_axi_rdata[0] == $past(s_reg.sync_level[s_reg.sel.last]);
  endproperty
  a_single_pin: assert property (p_single_pin)
    else $error("single pin read wrong");

  property p_range_align;
    @(posedge aclk) disable iff (!aresetn)
    q_read_of(OFS_RANGE_RES) |=>
      (s_axi_rdata & ~$past(span_mask)) == 32'h0 &&
      s_axi_rdata[0] == $past(s_reg.sync_level[s_reg.sel.last]) &&
      s_axi_rdata[$past(span)] == $past(s_reg.sync_level[s_reg.sel.first]);
  endproperty
  a_range_align: assert property (p_range_align)
    else $error("range read misaligned");

  property p_ro_write;
    @(posedge aclk) disable iff (!aresetn)
    (s_reg.aw.valid && s_reg.w.valid && !s_reg.bvalid &&
     s_reg.aw.addr == OFS_PORT_A) |=> s_axi_bvalid && s_axi_bresp == RESP_SLVERR
                                      && $stable(s_reg.sel);
  endproperty
  a_ro_write: assert property (p_ro_write)
    else $error("write to read-only port accepted");

  property p_bvalid_hold;
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold)
    else $error("write response dropped early");

  // write committed to one offset this cycle
  sequence q_commit_to(logic [3:0] a);
    s_reg.aw.valid && s_reg.w.valid && !s_reg.bvalid && (s_reg.aw.addr == a);
  endsequence

  property p_view_last;
    @(posedge aclk) disable iff (!aresetn)
    $past(aresetn, 3) |-> core_pin_levels[NUM_CORES-1] == $past(pins_in, 3);
  endproperty
  a_view_last: assert property (p_view_last)
    else $error("last core view does not match pins");

  property p_view_low;
    @(posedge aclk) disable iff (!aresetn)
    ($past(aresetn, 3) && !$past(pins_in[31], 3)) |-> !core_pin_levels[0][31];
  endproperty
  a_view_low: assert property (p_view_low)
    else $error("low pin read as one");

  property p_port_a_levels;
    @(posedge aclk) disable iff (!aresetn)
    (q_read_of(OFS_PORT_A) and ($past(aresetn, 1) && $past(aresetn, 2))) |=>
      s_axi_rdata == $past(pins_in, 3);
  endproperty
  a_port_a_levels: assert property (p_port_a_levels)
    else $error("port read differs from pin levels");

  property p_port_b_okay;
    @(posedge aclk) disable iff (!aresetn)
    q_read_of(OFS_PORT_B) |=> s_axi_rresp == RESP_OKAY;
  endproperty
  a_port_b_okay: assert property (p_port_b_okay)
    else $error("reserved port read refused");

  property p_sel_read;
    @(posedge aclk) disable iff (!aresetn)
    q_read_of(OFS_RANGE_SEL) |=>
      s_axi_rdata == {19'h0, $past(s_reg.sel.last), 3'h0, $past(s_reg.sel.first)};
  endproperty
  a_sel_read: assert property (p_sel_read)
    else $error("range select read back wrong");

  property p_sel_write;
    @(posedge aclk) disable iff (!aresetn)
    (q_commit_to(OFS_RANGE_SEL) and (s_reg.w.strb[1:0] == 2'h3)) |=>
      s_axi_bresp == RESP_OKAY &&
      s_reg.sel.first == $past(s_reg.w.data[SEL_FIRST_LSB +: PIN_IDX_W]) &&
      s_reg.sel.last == $past(s_reg.w.data[SEL_LAST_LSB +: PIN_IDX_W]);
  endproperty
  a_sel_write: assert property (p_sel_write)
    else $error("range select write lost");

  property p_res_write;
    @(posedge aclk) disable iff (!aresetn)
    q_commit_to(OFS_RANGE_RES) |=> s_axi_bvalid && s_axi_bresp == RESP_SLVERR
                                   && $stable(s_reg.sel);
  endproperty
  a_res_write: assert property (p_res_write)
    else $error("write to range result accepted");

  property p_unmapped_read;
    @(posedge aclk) disable iff (!aresetn)
    (ar_take && s_axi_araddr[1:0] != 2'h0) |=>
      s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("unmapped read not refused");

  property p_rvalid_hold;
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rvalid_hold: assert property (p_rvalid_hold)
    else $error("read data dropped early");

  property p_reset_idle;
    @(posedge aclk)
    !aresetn |=> s_axi_awready && s_axi_wready && s_axi_arready &&
                 !s_axi_bvalid && !s_axi_rvalid && core_pin_levels == '0;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("bus not idle after reset");

endmodule // gpioin_top

//--- rtl/gpioin_pkg.sv
// Purpose: constants and carrier types for the general-purpose input port reader
// Assumes: 32-bit AXI4-Lite register access, one aligned word per register
// Notes:   offsets are byte addresses inside a 16-byte window
package gpioin_pkg;

  // ==========================================================
  // register map
  localparam int          ADDR_W         = 4;
  localparam logic [3:0]  OFS_PORT_A     = 4'h0;
  localparam logic [3:0]  OFS_PORT_B     = 4'h4;
  localparam logic [3:0]  OFS_RANGE_SEL  = 4'h8;
  localparam logic [3:0]  OFS_RANGE_RES  = 4'hC;

  // ==========================================================
  // field layout of the range select register
  localparam int          SEL_FIRST_LSB  = 0;
  localparam int          SEL_LAST_LSB   = 8;
  localparam int          PIN_IDX_W      = 5;

  // ==========================================================
  // reset values and responses
  localparam logic [31:0] PORT_B_VALUE   = 32'h0000_0000;
  localparam logic [31:0] LEVELS_RESET   = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
  localparam int          SYNC_CYCLES    = 2;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [PIN_IDX_W-1:0] first;
    logic [PIN_IDX_W-1:0] last;
  } gpioin_range_sel_t;

  typedef struct packed {
    logic              valid;
    logic [ADDR_W-1:0] addr;
  } gpioin_addr_req_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] data;
    logic [3:0]  strb;
  } gpioin_wdata_req_t;

  // ==========================================================
  // right-aligned extraction; first-named pin lands on the top bit
  function automatic logic [31:0] gpioin_extract(
    input logic [31:0]          levels,
    input logic [PIN_IDX_W-1:0] first,
    input logic [PIN_IDX_W-1:0] last
  );
    logic [31:0] r;
    int          f;
    int          l;
    r = '0;
    f = int'(first);
    l = int'(last);
    for (int k = 0; k < 32; k++)
    begin
      if (f >= l)
      begin
        if (k <= f - l)
          r[k] = levels[l + k];
      end
      else
      begin
        if (k <= l - f)
          r[k] = levels[l - k];
      end
    end
    return r;
  endfunction

endpackage

//--- sim/gpioin_pins.sv
// Purpose: far-side model of the external signals on the 32 pins
// Assumes: levels requested by the bench are applied at a clock edge
// Notes:   levels are held until the next request, as real drivers would
`timescale 1ns/1ps
module gpioin_pins (
  input  wire logic        aclk,
  input  wire logic [31:0] level_req,
  output logic      [31:0] pins_in
);
  // ==========================================================
  // pin drivers
  // external drivers settle on the requested levels
  always @(posedge aclk)
  begin
    pins_in <= level_req;
  end
endmodule // gpioin_pins

//--- sim/test_gpioin_top.sv
// Purpose: self-checking bench for the pin level reader
// Assumes: AXI4-Lite master in the bench, pin model on the far side
// Notes:   pins held still several cycles before each read
`timescale 1ns/1ps
module test_gpioin_top;
  import gpioin_pkg::*;
  localparam int NC = 4;
  logic                 aclk    = 1'b0;
  logic                 aresetn = 1'b0;
  logic [31:0]          lvl     = 32'h0000_0000;
  logic [31:0]          pins;
  logic [NC-1:0][31:0]  views;
  logic [ADDR_W-1:0]    awaddr  = '0;
  logic [ADDR_W-1:0]    araddr  = '0;
  logic [31:0]          wdata   = 32'h0000_0000;
  logic [3:0]           wstrb   = 4'h0;
  logic                 awvalid = 1'b0;
  logic                 wvalid  = 1'b0;
  logic                 bready  = 1'b0;
  logic                 arvalid = 1'b0;
  logic                 rready  = 1'b0;
  logic                 awready, wready, bvalid, arready, rvalid;
  logic [1:0]           bresp, rresp, rs;
  logic [31:0]          rdata, rd, v;
  logic [4:0]           f, l;
  int                   errors   = 0;
  int                   compares = 0;
  logic [31:0]          corner [4] = '{32'h0000_0000, 32'hFFFF_FFFF, 32'h8000_0001, 32'h0001_0000};

  gpioin_pins PINS (.aclk(aclk), .level_req(lvl), .pins_in(pins));
  gpioin_top #(.NUM_CORES(NC)) DUT (
    .aclk(aclk), .aresetn(aresetn), .pins_in(pins), .core_pin_levels(views),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  // ==========================================================
  // clock, comparisons and verdict
  always #2 aclk = ~aclk;
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chk2(input logic [1:0] got, input logic [1:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %0t %s resp %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic final_report();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ==========================================================
  // bus master tasks
  task automatic rd_reg(input logic [ADDR_W-1:0] a);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] s);
    bit ta;
    bit tw;
    ta = 0;
    tw = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata  <= d;
    wstrb  <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (!ta && awready === 1'b1)
      begin
        ta = 1;
        awvalid <= 1'b0;
      end
      if (!tw && wready === 1'b1)
      begin
        tw = 1;
        wvalid <= 1'b0;
      end
    end
    while (!(ta && tw));
    do @(posedge aclk); while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask

  // ==========================================================
  // expectations
  function automatic logic [31:0] exp_rng(logic [31:0] p, int a, int b);
    logic [31:0] r;
    r = '0;
    for (int k = 0; k <= ((a >= b) ? a - b : b - a); k++)
      r[k] = (a >= b) ? p[b + k] : p[b - k];
    return r;
  endfunction
  task automatic set_pins(input logic [31:0] p);
    lvl <= p;
    repeat (6) @(posedge aclk);
  endtask

  // ==========================================================
  // tests
  initial
  begin
    v = $urandom(37);
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd_reg(OFS_RANGE_SEL);
    chk32(rd, 32'h0000_0000, "select reset");
    for (int i = 0; i < 8; i++)
    begin
      v = (i < 4) ? corner[i] : $urandom();
      set_pins(v);
      for (int c = 0; c < NC; c++) chk32(views[c], v, "core view");
      rd_reg(OFS_PORT_A);
      chk32(rd, v, "port a");
      chk2(rs, RESP_OKAY, "port a resp");
    end
    $display("test pin levels done");
    rd_reg(OFS_PORT_B);
    chk32(rd, PORT_B_VALUE, "port b");
    chk2(rs, RESP_OKAY, "port b resp");
    wr_reg(OFS_PORT_B, 32'hFFFF_FFFF, 4'hF);
    chk2(rs, RESP_SLVERR, "port b write");
    wr_reg(OFS_PORT_A, ~v, 4'hF);
    chk2(rs, RESP_SLVERR, "port a write");
    wr_reg(OFS_RANGE_RES, 32'hFFFF_FFFF, 4'hF);
    chk2(rs, RESP_SLVERR, "range result write");
    rd_reg(OFS_PORT_A);
    chk32(rd, v, "port a after write");
    rd_reg(4'h2);
    chk2(rs, RESP_SLVERR, "unmapped resp");
    chk32(rd, 32'h0000_0000, "unmapped data");
    $display("test refusals done");
    for (int i = 0; i < 24; i++)
    begin
      if (i % 8 == 0) set_pins($urandom());
      case (i)
        0: begin f = 5'd16; l = 5'd16; end
        1: begin f = 5'd18; l = 5'd15; end
        2: begin f = 5'd15; l = 5'd18; end
        3: begin f = 5'd31; l = 5'd0; end
        4: begin f = 5'd0; l = 5'd31; end
        default: begin f = 5'($urandom()); l = 5'($urandom()); end
      endcase
      wr_reg(OFS_RANGE_SEL, {19'h0, l, 3'h0, f}, 4'h3);
      chk2(rs, RESP_OKAY, "select write");
      rd_reg(OFS_RANGE_SEL);
      chk32(rd, {19'h0, l, 3'h0, f}, "select readback");
      rd_reg(OFS_RANGE_RES);
      chk32(rd, exp_rng(lvl, int'(f), int'(l)), "range result");
    end
    // one byte lane only: last pin field must survive
    wr_reg(OFS_RANGE_SEL, 32'h0000_0309, 4'h1);
    chk2(rs, RESP_OKAY, "lane write");
    rd_reg(OFS_RANGE_SEL);
    chk32(rd, {19'h0, l, 3'h0, 5'd9}, "lane select");
    $display("test ranges done");
    final_report();
  end

  // hang guard, far beyond the expected run length
  initial
  begin
    repeat (20000) @(posedge aclk);
    errors++;
    final_report();
  end
endmodule // test_gpioin_top
